/* shared/pwrseq_pkg.sv */
// constants for the power sequencing and status command registers
package pwrseq_pkg;
  // command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_PGOOD_THR = 8'h5e;
  localparam logic [7:0] CMD_TON_WAIT = 8'h60;
  localparam logic [7:0] CMD_TON_RAMP = 8'h61;
  localparam logic [7:0] CMD_TOFF_WAIT = 8'h64;
  localparam logic [7:0] CMD_TOFF_RAMP = 8'h65;
  localparam logic [7:0] CMD_STAT_BYTE = 8'h78;
  localparam logic [7:0] CMD_STAT_WORD = 8'h79;
  localparam logic [7:0] CMD_STAT_VOUT = 8'h7a;
  // reset values
  localparam logic [15:0] SEQ_TIME_RESET = 16'hca80;
  localparam logic [15:0] STAT_WORD_RESET = 16'h0000;
  localparam logic [7:0] STAT_BYTE_RESET = 8'h00;
  // 0.9 as a 0.16 fraction
  localparam logic [15:0] PGOOD_FRAC = 16'he666;
  // fault summary bit positions
  localparam int SB_BUSY = 7;
  localparam int SB_OFF = 6;
  localparam int SB_OV = 5;
  localparam int SB_OC = 4;
  localparam int SB_VIN_UV = 3;
  localparam int SB_TEMP = 2;
  localparam int SB_CML = 1;
  localparam int SB_OTHER = 0;
  localparam int SW_VOUT = 15;
  localparam int SW_IOUT = 14;
  localparam int SW_INPUT = 13;
  localparam int SW_MFG = 12;
  localparam int SW_PG_N = 11;
  localparam int SW_FAN = 10;
  localparam int SW_OTHER = 9;
  localparam int SW_UNKNOWN = 8;
  // timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned WAIT_MAX_MS = 500;
  localparam int unsigned RAMP_MAX_MS = 200;
  // gray coded sequencer states around the power cycle
  typedef enum logic [2:0] {
    SEQ_OFF = 3'b000,
    SEQ_ON_WAIT = 3'b001,
    SEQ_RAMP_UP = 3'b011,
    SEQ_ON = 3'b010,
    SEQ_OFF_WAIT = 3'b110,
    SEQ_RAMP_DN = 3'b100
  } seq_state_t;
endpackage

/* hw/bit_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
  parameter int unsigned W = 1
) (
  // clock
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] synced
);
  logic [W-1:0] meta_q, meta_d, sync_d;
  always_comb begin
    meta_d = ce ? d : meta_q;
    sync_d = ce ? meta_q : synced;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      synced <= '0;
    end else begin
      meta_q <= meta_d;
      synced <= sync_d;
    end
  end
endmodule // bit_sync
`default_nettype wire

/* hw/l11_to_cycles.sv */
// linear-11 millisecond word to clock cycle count
`timescale 1ns/100ps
`default_nettype none
module l11_to_cycles
  import pwrseq_pkg::*;
#(
  parameter int unsigned MS_CYC = 25000,
  parameter int unsigned MAX_MS = 500
) (
  // clock
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // conversion
  input wire logic [15:0] l11,
  output logic [31:0] cycles
);
  localparam logic [31:0] MAX_Q8 = 32'(MAX_MS * 256);
  localparam logic [31:0] MAX_CYC = 32'((64'(MAX_Q8) * MS_CYC) >> 8);
  logic signed [5:0] sh;
  logic [31:0] q8;
  logic [63:0] prod;
  logic [31:0] cyc_d;
  // R22 mantissa times two to exponent
  always_comb begin
    sh = $signed({l11[15], l11[15:11]}) + 6'sd8;
    q8 = '0;
    // negative times have no meaning, run as zero
    if (l11[10]) begin
      q8 = '0;
    end else if (sh > 6'sd21) begin
      q8 = MAX_Q8;
    end else if (!sh[5]) begin
      q8 = {22'h0, l11[9:0]} << sh[4:0];
    end else begin
      q8 = {22'h0, l11[9:0]} >> 6'(-sh);
    end
    if (q8 > MAX_Q8) q8 = MAX_Q8;
    prod = 64'(q8) * 64'(MS_CYC);
    cyc_d = prod[39:8];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cycles <= '0;
    end else if (ce) begin
      cycles <= cyc_d;
    end
  end
  cap_range_a: assert property (@(posedge clk) disable iff (!rst_n) cycles <= MAX_CYC) // R22
    else $error("converted time above range");
  five_ms_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
    ce && l11 == SEQ_TIME_RESET |=> cycles == 32'(5 * MS_CYC))
    else $error("default word is not five ms");
endmodule // l11_to_cycles
`default_nettype wire

/* hw/power_sequencing_status_regs.sv */
// power sequencing timers and status command registers
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R1: pgood on above threshold, off below limit
// R2: pgood threshold word, default 0.9 strap
// R3: turn-on wait default 5 ms, max 500
// R4: turn-on ramp default 5 ms, max 200
// R5: turn-off wait default 5 ms, max 500
// R6: turn-off ramp default 5 ms, max 200
// R7: time words are linear-11 milliseconds
// R8: byte bit 7 flags busy fault
// R9: byte bit 6 set while output unpowered
// R10: bits 5..1 ov, oc, vin uv, temp, cml
// R11: bit 0 flags faults not listed above
// R12: word low byte is the status byte
// R13: word bits 15..13 vout, iout, input summary
// R14: bit 12 maker, bit 11 pgood negated
// R15: bit 10 airflow, 9 other, 8 unknown
// R16: host picks detail read from summary
// R17: vout bits 7..4 ov/uv faults and warnings
// R18: vout bit 3 setpoint over maximum
// R19: vout bits 2..0 timeouts and tracking
// R20: status registers read-only, reset zero
// R21: latched faults cleared only by clear-faults
// R22: linear-11 scaled to cycle counts
// R23: wait then ramp on enable and disable
module power_sequencing_status_regs
  import pwrseq_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES
) (
  // core clock
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  // command link
  input wire logic lk_clk,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  // converter pins and sense
  input wire logic enable_pin,
  input wire logic [15:0] vout_strap,
  input wire logic [15:0] vout_sense,
  input wire logic [15:0] output_undervolt_limit,
  // fault events
  input wire logic output_overvolt_fault,
  input wire logic output_overcurrent_fault,
  input wire logic input_undervolt_fault,
  input wire logic temp_event,
  input wire logic comm_mem_logic_fault,
  input wire logic unlisted_fault,
  input wire logic output_current_power_summary,
  input wire logic input_summary,
  input wire logic maker_specific_summary,
  input wire logic airflow_summary,
  input wire logic other_status_any,
  input wire logic unknown_fault,
  input wire logic output_overvolt_warning,
  input wire logic output_undervolt_warning,
  input wire logic output_undervolt_fault,
  input wire logic setpoint_over_max_warning,
  input wire logic turn_on_timeout_fault,
  input wire logic turn_off_timeout_fault,
  input wire logic tracking_error,
  // sequencer outputs
  output logic power_good,
  output logic output_on,
  output logic ramp_up,
  output logic ramp_down
);
  // link domain
  logic pend_q, pend_d, req_t_q, req_t_d, ack_seen_q, ack_seen_d;
  logic busy_q, busy_d, wr_q, wr_d, rsp_v_d;
  logic [7:0] code_q, code_d;
  logic [15:0] wd_q, wd_d, rsp_d;
  logic ack_l;
  // core domain
  logic req_s, busy_s, en_s, req_seen_q, ack_t_q, new_req;
  logic [15:0] strap_s, rdata_q, rdata_d;
  logic [15:0] thr_q, thr_d, tonw_q, tonw_d, tonr_q, tonr_d;
  logic [15:0] toffw_q, toffw_d, toffr_q, toffr_d;
  logic [1:0] init_q, init_d;
  logic [31:0] strap_prod;
  logic is_rw, is_ro, is_clr, bad, clr;
  logic [7:0] sb_q, sb_d, swh_q, swh_d, vs_q, vs_d, sb_set, vs_set;
  logic [15:0] sw_set, sw_view;
  logic pg_q, pg_d;
  seq_state_t state_q, state_d;
  logic [31:0] cnt_q, cnt_d, lim;
  logic [31:0] tonw_c, tonr_c, toffw_c, toffr_c;
  logic on_d, rup_d, rdn_d;

  // link side: one command in flight, held stable while pending
  assign cmd_ready = !pend_q;
  always_comb begin
    pend_d = pend_q;
    req_t_d = req_t_q;
    ack_seen_d = ack_seen_q;
    wr_d = wr_q;
    code_d = code_q;
    wd_d = wd_q;
    rsp_d = rsp_rdata;
    rsp_v_d = 1'b0;
    // R8 offer while busy
    busy_d = cmd_valid && pend_q;
    if (cmd_valid && !pend_q) begin
      pend_d = 1'b1;
      req_t_d = !req_t_q;
      wr_d = cmd_write;
      code_d = cmd_code;
      wd_d = cmd_wdata;
    end
    // core result is stable once its ack toggle arrives
    if (ack_l != ack_seen_q) begin
      ack_seen_d = ack_l;
      pend_d = 1'b0;
      rsp_v_d = 1'b1;
      rsp_d = rdata_q;
    end
  end
  always_ff @(posedge lk_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 1'b0;
      req_t_q <= 1'b0;
      ack_seen_q <= 1'b0;
      busy_q <= 1'b0;
      wr_q <= 1'b0;
      code_q <= 8'h00;
      wd_q <= 16'h0000;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      pend_q <= pend_d;
      req_t_q <= req_t_d;
      ack_seen_q <= ack_seen_d;
      busy_q <= busy_d;
      wr_q <= wr_d;
      code_q <= code_d;
      wd_q <= wd_d;
      rsp_valid <= rsp_v_d;
      rsp_rdata <= rsp_d;
    end
  end
  bit_sync #(.W(1)) u_ack (.clk(lk_clk), .rst_n(arst_n), .ce(1'b1), .d(ack_t_q), .synced(ack_l));

  // crossings into the core
  bit_sync #(.W(1)) u_req (.clk(mclk), .rst_n(arst_n), .ce(ce), .d(req_t_q), .synced(req_s));
  bit_sync #(.W(1)) u_busy (.clk(mclk), .rst_n(arst_n), .ce(ce), .d(busy_q), .synced(busy_s));
  bit_sync #(.W(1)) u_en (.clk(mclk), .rst_n(arst_n), .ce(ce), .d(enable_pin), .synced(en_s));
  bit_sync #(.W(16)) u_strap (.clk(mclk), .rst_n(arst_n), .ce(ce), .d(vout_strap), .synced(strap_s));

  // R3 R4 R5 R6 clamped cycle counts
  l11_to_cycles #(.MS_CYC(MS_CYC), .MAX_MS(WAIT_MAX_MS)) u_tonw (
    .clk(mclk), .rst_n(arst_n), .ce(ce), .l11(tonw_q), .cycles(tonw_c));
  l11_to_cycles #(.MS_CYC(MS_CYC), .MAX_MS(RAMP_MAX_MS)) u_tonr (
    .clk(mclk), .rst_n(arst_n), .ce(ce), .l11(tonr_q), .cycles(tonr_c));
  l11_to_cycles #(.MS_CYC(MS_CYC), .MAX_MS(WAIT_MAX_MS)) u_toffw (
    .clk(mclk), .rst_n(arst_n), .ce(ce), .l11(toffw_q), .cycles(toffw_c));
  l11_to_cycles #(.MS_CYC(MS_CYC), .MAX_MS(RAMP_MAX_MS)) u_toffr (
    .clk(mclk), .rst_n(arst_n), .ce(ce), .l11(toffr_q), .cycles(toffr_c));

  // command decode and register file
  assign new_req = req_s != req_seen_q;
  always_comb begin
    is_rw = code_q == CMD_PGOOD_THR || code_q == CMD_TON_WAIT || code_q == CMD_TON_RAMP
         || code_q == CMD_TOFF_WAIT || code_q == CMD_TOFF_RAMP;
    is_ro = code_q == CMD_STAT_BYTE || code_q == CMD_STAT_WORD || code_q == CMD_STAT_VOUT;
    is_clr = code_q == CMD_CLEAR_FAULTS && wr_q;
    // R20 writes to status codes refused
    bad = new_req && ((wr_q && !is_rw && !is_clr) || (!wr_q && !is_rw && !is_ro));
    clr = new_req && is_clr;
    thr_d = thr_q;
    tonw_d = tonw_q;
    tonr_d = tonr_q;
    toffw_d = toffw_q;
    toffr_d = toffr_q;
    init_d = init_q;
    strap_prod = 32'(strap_s) * 32'(PGOOD_FRAC);
    // R2 strap caught once sync is full
    if (init_q == 2'd2) begin
      thr_d = strap_prod[31:16];
    end
    if (init_q != 2'd3) init_d = init_q + 2'd1;
    // R7 time words stored as written
    if (new_req && wr_q) begin
      if (code_q == CMD_PGOOD_THR) begin
        thr_d = wd_q;
      end else if (code_q == CMD_TON_WAIT) begin
        tonw_d = wd_q;
      end else if (code_q == CMD_TON_RAMP) begin
        tonr_d = wd_q;
      end else if (code_q == CMD_TOFF_WAIT) begin
        toffw_d = wd_q;
      end else if (code_q == CMD_TOFF_RAMP) begin
        toffr_d = wd_q;
      end
    end
    rdata_d = rdata_q;
    if (new_req) begin
      if (code_q == CMD_PGOOD_THR) begin
        rdata_d = thr_q;
      end else if (code_q == CMD_TON_WAIT) begin
        rdata_d = tonw_q;
      end else if (code_q == CMD_TON_RAMP) begin
        rdata_d = tonr_q;
      end else if (code_q == CMD_TOFF_WAIT) begin
        rdata_d = toffw_q;
      end else if (code_q == CMD_TOFF_RAMP) begin
        rdata_d = toffr_q;
      end else if (code_q == CMD_STAT_BYTE) begin
        // R12 byte is the word's low half
        rdata_d = {8'h00, sw_view[7:0]};
      end else if (code_q == CMD_STAT_WORD) begin
        rdata_d = sw_view;
      end else if (code_q == CMD_STAT_VOUT) begin
        rdata_d = {8'h00, vs_q};
      end else begin
        rdata_d = 16'h0000;
      end
    end
  end

  // status latches
  always_comb begin
    // R17 R18 R19 vout status order
    vs_set = {output_overvolt_fault, output_overvolt_warning, output_undervolt_warning,
              output_undervolt_fault, setpoint_over_max_warning, turn_on_timeout_fault,
              turn_off_timeout_fault, tracking_error};
    sb_set = 8'h00;
    // R8 busy
    sb_set[SB_BUSY] = busy_s;
    // R10 critical faults
    sb_set[SB_OV] = output_overvolt_fault;
    sb_set[SB_OC] = output_overcurrent_fault;
    sb_set[SB_VIN_UV] = input_undervolt_fault;
    sb_set[SB_TEMP] = temp_event;
    sb_set[SB_CML] = comm_mem_logic_fault || bad;
    // R11 everything else, vout ov already in bit 5
    sb_set[SB_OTHER] = unlisted_fault || (|vs_set[6:0]);
    sw_set = 16'h0000;
    // R13 summaries
    sw_set[SW_VOUT] = |vs_set;
    sw_set[SW_IOUT] = output_overcurrent_fault || output_current_power_summary;
    sw_set[SW_INPUT] = input_undervolt_fault || input_summary;
    // R14 R15 summaries
    sw_set[SW_MFG] = maker_specific_summary;
    sw_set[SW_FAN] = airflow_summary;
    sw_set[SW_UNKNOWN] = unknown_fault;
    // R21 set wins over clear
    sb_d = (sb_q & ~{8{clr}}) | sb_set;
    swh_d = (swh_q & ~{8{clr}}) | sw_set[15:8];
    vs_d = (vs_q & ~{8{clr}}) | vs_set;
    sw_view = {swh_q, sb_q};
    // R14 live pgood negation
    sw_view[SW_PG_N] = !pg_q;
    // R15 live copy of other status
    sw_view[SW_OTHER] = other_status_any;
    // R9 off until the ramp starts
    sw_view[SB_OFF] = state_q == SEQ_OFF || state_q == SEQ_ON_WAIT;
  end

  // power good and sequencer
  always_comb begin
    pg_d = pg_q;
    // R1 hysteresis between two thresholds
    if (vout_sense > thr_q) begin
      pg_d = 1'b1;
    end else if (vout_sense < output_undervolt_limit) begin
      pg_d = 1'b0;
    end
    case (state_q)
      SEQ_ON_WAIT: lim = tonw_c;
      SEQ_RAMP_UP: lim = tonr_c;
      SEQ_OFF_WAIT: lim = toffw_c;
      SEQ_RAMP_DN: lim = toffr_c;
      default: lim = 32'h0000_0000;
    endcase
    state_d = state_q;
    cnt_d = cnt_q + 32'h0000_0001;
    // R23 wait then ramp each way
    case (state_q)
      SEQ_OFF: begin
        if (en_s) state_d = SEQ_ON_WAIT;
      end
      SEQ_ON_WAIT: begin
        if (!en_s) state_d = SEQ_OFF;
        else if (cnt_q >= lim) state_d = SEQ_RAMP_UP;
      end
      SEQ_RAMP_UP: begin
        if (cnt_q >= lim) state_d = SEQ_ON;
      end
      SEQ_ON: begin
        if (!en_s) state_d = SEQ_OFF_WAIT;
      end
      SEQ_OFF_WAIT: begin
        if (en_s) state_d = SEQ_ON;
        else if (cnt_q >= lim) state_d = SEQ_RAMP_DN;
      end
      SEQ_RAMP_DN: begin
        // a ramp down always finishes before a new start
        if (cnt_q >= lim) state_d = SEQ_OFF;
      end
      default: state_d = SEQ_OFF;
    endcase
    if (state_d != state_q) cnt_d = 32'h0000_0000;
    on_d = state_d != SEQ_OFF;
    rup_d = state_d == SEQ_RAMP_UP;
    rdn_d = state_d == SEQ_RAMP_DN;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      req_seen_q <= 1'b0;
      ack_t_q <= 1'b0;
      rdata_q <= 16'h0000;
      thr_q <= 16'h0000;
      // R3 R4 R5 R6 five ms defaults
      tonw_q <= SEQ_TIME_RESET;
      tonr_q <= SEQ_TIME_RESET;
      toffw_q <= SEQ_TIME_RESET;
      toffr_q <= SEQ_TIME_RESET;
      init_q <= 2'd0;
      sb_q <= STAT_BYTE_RESET;
      swh_q <= STAT_WORD_RESET[15:8];
      vs_q <= STAT_BYTE_RESET;
      pg_q <= 1'b0;
      state_q <= SEQ_OFF;
      cnt_q <= 32'h0000_0000;
      output_on <= 1'b0;
      ramp_up <= 1'b0;
      ramp_down <= 1'b0;
    end else if (ce) begin
      req_seen_q <= req_s;
      ack_t_q <= ack_t_q ^ new_req;
      rdata_q <= rdata_d;
      thr_q <= thr_d;
      tonw_q <= tonw_d;
      tonr_q <= tonr_d;
      toffw_q <= toffw_d;
      toffr_q <= toffr_d;
      init_q <= init_d;
      sb_q <= sb_d;
      swh_q <= swh_d;
      vs_q <= vs_d;
      pg_q <= pg_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      output_on <= on_d;
      ramp_up <= rup_d;
      ramp_down <= rdn_d;
    end
  end
  assign power_good = pg_q;

  pgood_rise_a: assert property (@(posedge mclk) disable iff (!arst_n) // R1
    ce && vout_sense > thr_q |=> power_good) else $error("pgood did not assert");
  pgood_keep_a: assert property (@(posedge mclk) disable iff (!arst_n) // R1
    ce && power_good && vout_sense >= output_undervolt_limit |=> power_good)
    else $error("pgood dropped above limit");
  busy_latch_a: assert property (@(posedge mclk) disable iff (!arst_n) // R8
    ce && busy_s ##1 (!clr)[*2] |-> sb_q[SB_BUSY]) else $error("busy not latched");
  off_view_a: assert property (@(posedge mclk) disable iff (!arst_n) // R9
    !output_on |-> sw_view[SB_OFF]) else $error("off bit clear while unpowered");
  ov_both_a: assert property (@(posedge mclk) disable iff (!arst_n) // R10
    ce && output_overvolt_fault |=> sb_q[SB_OV] && vs_q[7] && swh_q[SW_VOUT - 8])
    else $error("ov fault not latched everywhere");
  pg_bit_a: assert property (@(posedge mclk) disable iff (!arst_n) // R14
    $fell(power_good) |-> sw_view[SW_PG_N]) else $error("pgood negation bit clear");
  fault_hold_a: assert property (@(posedge mclk) disable iff (!arst_n) // R21
    vs_q[0] && !clr |=> vs_q[0]) else $error("fault bit lost without clear");
  fault_clear_a: assert property (@(posedge mclk) disable iff (!arst_n) // R21
    ce && clr && vs_set == 8'h00 |=> vs_q == STAT_BYTE_RESET) else $error("clear left bits");
  wait_hold_a: assert property (@(posedge mclk) disable iff (!arst_n) // R23
    ce && state_q == SEQ_ON_WAIT && en_s && cnt_q < tonw_c |=> state_q == SEQ_ON_WAIT)
    else $error("turn-on wait cut short");
  word_write_a: assert property (@(posedge mclk) disable iff (!arst_n) // R7
    ce && new_req && wr_q && code_q == CMD_TON_RAMP |=> tonr_q == $past(wd_q))
    else $error("ramp word not stored");
endmodule // power_sequencing_status_regs
`default_nettype wire

/* verification/pmbus_host.sv */
// host side model of the command link
`timescale 1ns/100ps
`default_nettype none
module pmbus_host (
  // link clock
  input wire logic lk_clk,
  // command link
  output var logic cmd_valid,
  input wire logic cmd_ready,
  output var logic cmd_write,
  output var logic [7:0] cmd_code,
  output var logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata
);
  // waits that run out, counted as mismatches by the bench
  int n_stalls = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // bounded wait, answer taken at the edge it is seen
  task automatic wait_rsp(output logic [15:0] q);
    int n;
    n = 0;
    do begin
      @(posedge lk_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 64);
    if (rsp_valid !== 1'b1) n_stalls++;
    q = rsp_rdata;
  endtask
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, input bit hold,
                      output logic [15:0] q);
    int n;
    n = 0;
    @(posedge lk_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    do begin
      @(posedge lk_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 64);
    if (cmd_ready !== 1'b1) n_stalls++;
    // hold offers a second command while busy, on purpose
    if (hold) begin
      wait_rsp(q);
    end
    #1;
    cmd_valid = 1'b0;
    // released lines show the inverse, not the last value
    cmd_write = ~cmd_write;
    cmd_code = ~cmd_code;
    cmd_wdata = ~cmd_wdata;
    wait_rsp(q);
  endtask
endmodule // pmbus_host
`default_nettype wire

/* verification/power_sequencing_status_regs_test.sv */
// self-checking bench for the power sequencing and status registers
`timescale 1ns/100ps
`default_nettype none
module power_sequencing_status_regs_test
  import pwrseq_pkg::*;
;
  // short millisecond keeps the ramps brief
  localparam int unsigned MSC = 16;
  localparam int LIMIT = 40000;
  logic mclk = 1'b0;
  logic lk_clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic cmd_valid, cmd_ready, cmd_write, rsp_valid;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_rdata;
  logic enable_pin = 1'b0;
  logic [15:0] vout_strap = 16'h4000;
  logic [15:0] vout_sense = 16'h0000;
  logic [15:0] uv_limit = 16'h2000;
  logic [17:0] ev = '0;
  logic other_any = 1'b0;
  logic power_good, output_on, ramp_up, ramp_down;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  always #20 mclk = ~mclk;
  initial begin
    #7;
    forever #80 lk_clk = ~lk_clk;
  end
  power_sequencing_status_regs #(.MS_CYC(MSC)) i_dut (
    .mclk(mclk), .arst_n(arst_n), .ce(ce), .lk_clk(lk_clk),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .enable_pin(enable_pin), .vout_strap(vout_strap), .vout_sense(vout_sense),
    .output_undervolt_limit(uv_limit),
    .output_overvolt_fault(ev[0]), .output_overcurrent_fault(ev[1]), .input_undervolt_fault(ev[2]),
    .temp_event(ev[3]), .comm_mem_logic_fault(ev[4]), .unlisted_fault(ev[5]),
    .output_current_power_summary(ev[6]), .input_summary(ev[7]), .maker_specific_summary(ev[8]),
    .airflow_summary(ev[9]), .other_status_any(other_any), .unknown_fault(ev[10]),
    .output_overvolt_warning(ev[11]), .output_undervolt_warning(ev[12]),
    .output_undervolt_fault(ev[13]), .setpoint_over_max_warning(ev[14]),
    .turn_on_timeout_fault(ev[15]), .turn_off_timeout_fault(ev[16]), .tracking_error(ev[17]),
    .power_good(power_good), .output_on(output_on), .ramp_up(ramp_up), .ramp_down(ramp_down));
  pmbus_host i_host (
    .lk_clk(lk_clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  task automatic close_out();
    n_errors = n_errors + i_host.n_stalls;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      close_out();
    end
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] exp, input logic [15:0] m);
    logic [15:0] q;
    i_host.xfer(1'b0, c, 16'h0000, 1'b0, q);
    check($sformatf("cmd %h", c), exp & m, q & m);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] q;
    i_host.xfer(1'b1, c, d, 1'b0, q);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  function automatic logic sel(input int k);
    return k == 0 ? output_on : (k == 1 ? ramp_up : ramp_down);
  endfunction
  // cycles until the chosen output reaches the level
  task automatic span(input int k, input logic lvl, output int n);
    n = 0;
    while (sel(k) !== lvl && n < 5000) begin
      ticks(1);
      n++;
    end
  endtask
  function automatic logic [15:0] ev_word(input int i);
    case (i)
      0: return 16'h8020;
      1: return 16'h4010;
      2: return 16'h2008;
      3: return 16'h0004;
      4: return 16'h0002;
      5: return 16'h0001;
      6: return 16'h4000;
      7: return 16'h2000;
      8: return 16'h1000;
      9: return 16'h0400;
      10: return 16'h0100;
      default: return 16'h8001;
    endcase
  endfunction
  task automatic t_reset();
    rd(CMD_TON_WAIT, SEQ_TIME_RESET, 16'hffff);
    rd(CMD_TON_RAMP, SEQ_TIME_RESET, 16'hffff);
    rd(CMD_TOFF_WAIT, SEQ_TIME_RESET, 16'hffff);
    rd(CMD_TOFF_RAMP, SEQ_TIME_RESET, 16'hffff);
    rd(CMD_PGOOD_THR, 16'((32'(vout_strap) * 32'(PGOOD_FRAC)) >> 16), 16'hffff);
    rd(CMD_STAT_BYTE, 16'h0040, 16'hffff);
    rd(CMD_STAT_WORD, 16'h0840, 16'hffff);
    rd(CMD_STAT_VOUT, 16'h0000, 16'hffff);
  endtask
  task automatic t_access();
    logic [15:0] q;
    wr(CMD_TON_WAIT, 16'h0002);
    rd(CMD_TON_WAIT, 16'h0002, 16'hffff);
    wr(CMD_STAT_WORD, 16'hffff);
    rd(CMD_STAT_WORD, 16'h0842, 16'hffff);
    rd(CMD_STAT_BYTE, 16'h0042, 16'hffff);
    rd(8'h7b, 16'h0000, 16'hffff);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    rd(CMD_STAT_WORD, 16'h0840, 16'hffff);
    i_host.xfer(1'b0, CMD_STAT_VOUT, 16'h0000, 1'b1, q);
    rd(CMD_STAT_BYTE, 16'h00c0, 16'hffff);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
  endtask
  task automatic t_events();
    logic [15:0] w, v, m;
    // frozen core must not latch an event
    ce = 1'b0;
    ticks(1);
    ev[0] = 1'b1;
    ticks(1);
    ev[0] = 1'b0;
    ce = 1'b1;
    ticks(2);
    rd(CMD_STAT_VOUT, 16'h0000, 16'hffff);
    rd(CMD_STAT_WORD, 16'h0840, 16'hffff);
    for (int i = 0; i < 18; i++) begin
      w = 16'h0840 | ev_word(i);
      v = i == 0 ? 16'h0080 : (i >= 11 ? 16'(16'h0080 >> (i - 10)) : 16'h0000);
      // bit 0 for the other summaries is left open
      m = (i >= 6 && i <= 10) ? 16'hfffe : 16'hffff;
      ticks(1);
      ev[i] = 1'b1;
      ticks(1);
      ev[i] = 1'b0;
      ticks(2);
      rd(CMD_STAT_WORD, w, m);
      rd(CMD_STAT_BYTE, {8'h00, w[7:0]}, m);
      rd(CMD_STAT_VOUT, v, 16'hffff);
      rd(CMD_STAT_WORD, w, m);
      wr(CMD_CLEAR_FAULTS, 16'h0000);
      rd(CMD_STAT_WORD, 16'h0840, 16'hffff);
      rd(CMD_STAT_VOUT, 16'h0000, 16'hffff);
    end
    other_any = 1'b1;
    ticks(2);
    rd(CMD_STAT_WORD, 16'h0a40, 16'hffff);
    other_any = 1'b0;
    ticks(2);
    rd(CMD_STAT_WORD, 16'h0840, 16'hffff);
  endtask
  task automatic t_seq();
    int n;
    // 250 ms is above the ramp range and must clamp
    wr(CMD_TON_RAMP, 16'h00fa);
    rd(CMD_TON_RAMP, 16'h00fa, 16'hffff);
    wr(CMD_TOFF_RAMP, 16'hf806);
    ticks(1);
    enable_pin = 1'b1;
    span(0, 1'b1, n);
    span(1, 1'b1, n);
    check("turn_on_wait cycles", 16'(2 * MSC + 1), 16'(n));
    span(1, 1'b0, n);
    check("turn_on_ramp cycles", 16'(200 * MSC + 1), 16'(n));
    rd(CMD_STAT_BYTE, 16'h0000, 16'hffff);
    vout_sense = 16'h3a00;
    ticks(3);
    check("power_good high", 16'h0001, {15'h0000, power_good});
    rd(CMD_STAT_WORD, 16'h0000, 16'hffff);
    vout_sense = 16'h3000;
    ticks(3);
    check("power_good held", 16'h0001, {15'h0000, power_good});
    vout_sense = 16'h1f00;
    ticks(3);
    check("power_good low", 16'h0000, {15'h0000, power_good});
    enable_pin = 1'b0;
    span(2, 1'b1, n);
    // two sync stages and the leaving edge come before the wait
    check("turn_off_wait cycles", 16'(5 * MSC + 4), 16'(n));
    span(2, 1'b0, n);
    check("turn_off_ramp cycles", 16'(3 * MSC + 1), 16'(n));
    check("output_on after off", 16'h0000, {15'h0000, output_on});
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    ticks(6);
    t_reset();
    t_access();
    t_events();
    t_seq();
    close_out();
  end
endmodule // power_sequencing_status_regs_test
`default_nettype wire
